// *** core/ccfr_defs.vh ***
// Register offsets, field positions, reset values and scale constants
`ifndef CCFR_DEFS_VH
`define CCFR_DEFS_VH
`define CCFR_ADDR_W 8
`define CCFR_OFS_MASK 8'h0A
`define CCFR_OFS_VREG 8'h12
`define CCFR_OFS_FAST_CHARGE_CURRENT_CODE 8'h13
`define CCFR_OFS_PCHG 8'h14
`define CCFR_OFS_TERM 8'h15
`define CCFR_RST_MASK 8'h00
`define CCFR_RST_VREG 8'h3C
`define CCFR_RST_FAST_CHARGE_CURRENT_CODE 8'h08
`define CCFR_RST_PCHG 8'h02
`define CCFR_RST_TERM 8'h14
`define CCFR_BIT_WD 6
`define CCFR_BIT_SAFETY 5
`define CCFR_BIT_LDO_OCP 4
`define CCFR_BIT_IMAX 3
`define CCFR_BIT_WAKE1 2
`define CCFR_BIT_WAKE2 1
`define CCFR_BIT_RSTWARN 0
`define CCFR_BIT_RANGE 7
`define CCFR_BIT_TERM_DIS 0
`define CCFR_VREG_MSB 6
`define CCFR_PCHG_MSB 4
`define CCFR_TERM_MSB 5
`define CCFR_TERM_LSB 1
// Base 3600 mV, 10 mV per code; 4600 mV ceiling is code 100
`define CCFR_VREG_BASE_MV 13'h0E10
`define CCFR_VREG_STEP_MV 13'h000A
`define CCFR_VREG_MAX_CODE 7'h64
// Currents in units of 0.25 mA: 1.25 mA = 5, 2.5 mA = 10
`define CCFR_STEP_LO_QMA 4'h5
`define CCFR_STEP_HI_QMA 4'hA
`define CCFR_PCT_DIV 24'h000064
`endif

// *** core/ccfr_regs.v ***
// Charger configuration and fault interrupt mask register bank
//
// Overview of operation
// - Mask bit 6 set blocks the watchdog fault interrupt.
// - Mask bit 5 set blocks the safety timer fault interrupt.
// - Mask bit 4 set blocks the regulator over-current interrupt.
// - Mask bit 3 set blocks the maximum-current fault interrupt.
// - Mask bit 2 set blocks the first button wake timer interrupt.
// - Mask bit 1 set blocks the second button wake timer interrupt.
// - Mask bit 0 set blocks the button reset-warning interrupt.
// - Regulation voltage is 3600 mV plus code times 10 mV.
// - Codes above 4.6 V are saturated to the 4.6 V code.
// - Fast charge current is code times 1.25 mA or 2.5 mA.
// - Range bit picks 1.25 mA or 2.5 mA step size.
// - Pre-charge current is 5-bit code times selected step.
// - Termination current is code percent of fast charge current.
// - Termination disable bit set turns charge termination off.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ccfr_defs.vh"
module ccfr_regs (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // Register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Raw fault events
  input wire [6:0] i_fault_evt,
  // Masked fault events
  output reg [6:0] o_fault_irq,
  // Charger settings
  output reg [12:0] o_regulation_voltage_mv,
  output reg [11:0] o_programmed_charge_current_qma,
  output reg [8:0] o_precharge_current_qma,
  output reg [11:0] o_term_current_qma,
  output reg o_term_enable
);
  reg [7:0] mask_q;
  reg [7:0] vreg_q;
  reg [7:0] fast_charge_current_code_q;
  reg [7:0] pchg_q;
  reg [7:0] term_q;
  reg [7:0] wvreg_d;
  reg [7:0] rdata_d;
  wire [3:0] step_w;
  wire [11:0] fast_charge_current_code_w;
  wire [4:0] term_pct_w;
  wire [23:0] term_prod_w;

  // Selected step in quarter milliamps
  function [3:0] step_of;
    input range_bit;
    begin
      step_of = range_bit ? `CCFR_STEP_HI_QMA : `CCFR_STEP_LO_QMA;
    end
  endfunction

  // Saturate voltage code at the ceiling
  always @* begin
    wvreg_d = i_wdata;
    if (i_wdata[`CCFR_VREG_MSB:0] > `CCFR_VREG_MAX_CODE) begin
      wvreg_d = {i_wdata[7], `CCFR_VREG_MAX_CODE};
    end
  end

  // Register writes; reserved bits stored as written
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mask_q <= `CCFR_RST_MASK;
      vreg_q <= `CCFR_RST_VREG;
      fast_charge_current_code_q <= `CCFR_RST_FAST_CHARGE_CURRENT_CODE;
      pchg_q <= `CCFR_RST_PCHG;
      term_q <= `CCFR_RST_TERM;
    end else if (i_wr) begin
      case (i_addr)
        `CCFR_OFS_MASK: mask_q <= i_wdata;
        `CCFR_OFS_VREG: vreg_q <= wvreg_d;
        `CCFR_OFS_FAST_CHARGE_CURRENT_CODE: fast_charge_current_code_q <= i_wdata;
        `CCFR_OFS_PCHG: pchg_q <= i_wdata;
        `CCFR_OFS_TERM: term_q <= i_wdata;
        default: mask_q <= mask_q;
      endcase
    end
  end

  // Read mux, unmapped reads zero
  always @* begin
    rdata_d = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `CCFR_OFS_MASK: rdata_d = mask_q;
        `CCFR_OFS_VREG: rdata_d = vreg_q;
        `CCFR_OFS_FAST_CHARGE_CURRENT_CODE: rdata_d = fast_charge_current_code_q;
        `CCFR_OFS_PCHG: rdata_d = pchg_q;
        `CCFR_OFS_TERM: rdata_d = term_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  assign step_w = step_of(pchg_q[`CCFR_BIT_RANGE]);
  assign fast_charge_current_code_w = fast_charge_current_code_q * step_w;
  assign term_pct_w = term_q[`CCFR_TERM_MSB:`CCFR_TERM_LSB];
  assign term_prod_w = (fast_charge_current_code_w * term_pct_w) / `CCFR_PCT_DIV;

  // Registered outputs
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_fault_irq <= 7'h00;
      o_regulation_voltage_mv <= 13'h0000;
      o_programmed_charge_current_qma <= 12'h000;
      o_precharge_current_qma <= 9'h000;
      o_term_current_qma <= 12'h000;
      o_term_enable <= 1'b0;
    end else begin
      o_rdata <= rdata_d;
      o_fault_irq[`CCFR_BIT_WD] <= i_fault_evt[`CCFR_BIT_WD] & ~mask_q[`CCFR_BIT_WD];
      o_fault_irq[`CCFR_BIT_SAFETY] <= i_fault_evt[`CCFR_BIT_SAFETY] & ~mask_q[`CCFR_BIT_SAFETY];
      o_fault_irq[`CCFR_BIT_LDO_OCP] <= i_fault_evt[`CCFR_BIT_LDO_OCP] & ~mask_q[`CCFR_BIT_LDO_OCP];
      o_fault_irq[`CCFR_BIT_IMAX] <= i_fault_evt[`CCFR_BIT_IMAX] & ~mask_q[`CCFR_BIT_IMAX];
      o_fault_irq[`CCFR_BIT_WAKE1] <= i_fault_evt[`CCFR_BIT_WAKE1] & ~mask_q[`CCFR_BIT_WAKE1];
      o_fault_irq[`CCFR_BIT_WAKE2] <= i_fault_evt[`CCFR_BIT_WAKE2] & ~mask_q[`CCFR_BIT_WAKE2];
      o_fault_irq[`CCFR_BIT_RSTWARN] <= i_fault_evt[`CCFR_BIT_RSTWARN] & ~mask_q[`CCFR_BIT_RSTWARN];
      o_regulation_voltage_mv <= `CCFR_VREG_BASE_MV
        + vreg_q[`CCFR_VREG_MSB:0] * `CCFR_VREG_STEP_MV;
      o_programmed_charge_current_qma <= fast_charge_current_code_w;
      o_precharge_current_qma <= pchg_q[`CCFR_PCHG_MSB:0] * step_w;
      o_term_current_qma <= term_prod_w[11:0];
      o_term_enable <= ~term_q[`CCFR_BIT_TERM_DIS];
    end
  end
endmodule // ccfr_regs
`default_nettype wire

// *** verif/ccfr_regs_chk.sv ***
// Port checker for the charger register bank
`timescale 1ns/10ps
`default_nettype none
module ccfr_regs_chk (
  input wire logic i_clk_sys, i_rst, i_wr, i_rd, o_term_enable,
  input wire logic [7:0] i_addr, i_wdata, o_rdata,
  input wire logic [6:0] i_fault_evt, o_fault_irq,
  input wire logic [12:0] o_regulation_voltage_mv,
  input wire logic [11:0] o_programmed_charge_current_qma, o_term_current_qma,
  input wire logic [8:0] o_precharge_current_qma
);
  // Mask bits, with the step select bit on top
  logic [7:0] m_q;
  wire wr_fast = i_wr && i_addr == 8'h13;
  wire wr_term = i_wr && i_addr == 8'h15;
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst) m_q <= 8'h00;
    else if (i_wr) m_q <= {i_addr == 8'h14 ? i_wdata[7] : m_q[7], i_addr == 8'h0A ? i_wdata[6:0] : m_q[6:0]};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_irq_gate:
  assert property (!$past(i_rst) |-> o_fault_irq == ($past(i_fault_evt) & ~$past(m_q[6:0]))) else $error("irq");
  a_vreg_clamp:
  assert property (i_wr && i_addr == 8'h12 && i_wdata[6:0] > 7'h64 |=> ##1 o_regulation_voltage_mv == 13'h11F8)
    else $error("clamp");
  a_fast_step:
  assert property (wr_fast |-> ##2 o_programmed_charge_current_qma == $past(i_wdata, 2) * ($past(m_q[7]) ? 10 : 5))
    else $error("fast");
  a_pre_step:
  assert property (i_wr && i_addr == 8'h14 |-> ##2
    o_precharge_current_qma == $past(i_wdata[4:0], 2) * ($past(i_wdata[7], 2) ? 10 : 5)) else $error("pre");
  a_term_pct:
  assert property (wr_term |-> ##2 o_term_current_qma == o_programmed_charge_current_qma * $past(i_wdata[5:1], 2) / 100)
    else $error("term");
  a_term_off:
  assert property (wr_term |-> ##2 o_term_enable == !$past(i_wdata[0], 2)) else $error("enable");
  a_rdata_idle:
  assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata");
  a_mask_read:
  assert property (i_rd && i_addr == 8'h0A |=> o_rdata[6:0] == $past(m_q[6:0])) else $error("readback");
endmodule // ccfr_regs_chk
bind ccfr_regs ccfr_regs_chk i_ccfr_regs_chk (.*);
`default_nettype wire

// *** verif/ccfr_host.sv ***
// Host model on the register port
`timescale 1ns/10ps
`default_nettype none
module ccfr_host (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr, o_wdata,
  output logic o_wr, o_rd
);
  initial {o_addr, o_wdata, o_wr, o_rd} = 18'h00000;
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge i_clk_sys);
    {o_wr, o_rd, o_addr, o_wdata} <= {w, !w, a, d};
    @(posedge i_clk_sys);
    {o_wr, o_rd} <= 2'h0;
    @(negedge i_clk_sys);
    q = i_rdata;
  endtask
endmodule // ccfr_host
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr, i_rd, o_term_enable;
  logic [7:0] i_addr, i_wdata, o_rdata, q;
  logic [6:0] i_fault_evt = 7'h00;
  logic [6:0] o_fault_irq;
  logic [12:0] o_regulation_voltage_mv;
  logic [11:0] o_programmed_charge_current_qma, o_term_current_qma;
  logic [8:0] o_precharge_current_qma;
  int num_errors = 0;
  int comparisons = 0;
  // Address, reset value, write data, readback
  logic [31:0] rows [6] = '{32'h0A00FFFF, 32'h123CFFE4, 32'h1308FFFF, 32'h1402E1E1, 32'h1514C3C3, 32'h40005500};
  wire [46:0] outs = {o_regulation_voltage_mv, o_programmed_charge_current_qma, o_precharge_current_qma,
    o_term_current_qma, o_term_enable};
  always #25 i_clk_sys = ~i_clk_sys;
  ccfr_regs i_ccfr_regs (.*);
  ccfr_host i_ccfr_host (.i_clk_sys, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
  task automatic check(input logic [46:0] g, e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t %h %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (2) @(negedge i_clk_sys);
    check(outs, {13'h1068, 12'h028, 9'h00A, 12'h004, 1'h1});
    foreach (rows[k]) begin
      i_ccfr_host.xfer(1'b0, rows[k][31:24], 8'h00, q);
      check(q, rows[k][23:16]);
      i_ccfr_host.xfer(1'b1, rows[k][31:24], rows[k][15:8], q);
      i_ccfr_host.xfer(1'b0, rows[k][31:24], 8'h00, q);
      check(q, rows[k][7:0]);
    end
    check(outs, {13'h11F8, 12'h9F6, 9'h00A, 12'h019, 1'h0});
    @(posedge i_clk_sys);
    i_fault_evt <= 7'h7F;
    for (int b = 0; b < 7; b++) begin
      i_ccfr_host.xfer(1'b1, 8'h0A, ~(8'h01 << b), q);
      @(negedge i_clk_sys);
      check(o_fault_irq, 47'h1 << b);
    end
    i_ccfr_host.xfer(1'b1, 8'h14, 8'h1F, q);
    i_ccfr_host.xfer(1'b1, 8'h12, 8'h00, q);
    i_ccfr_host.xfer(1'b1, 8'h15, 8'h3E, q);
    @(negedge i_clk_sys);
    check(outs, {13'h0E10, 12'h4FB, 9'h09B, 12'h18B, 1'h1});
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (2) @(negedge i_clk_sys);
    check(outs, {13'h1068, 12'h028, 9'h00A, 12'h004, 1'h1});
    check(o_fault_irq, 47'h7F);
    i_ccfr_host.xfer(1'b0, 8'h0A, 8'h00, q);
    check(q, 47'h00);
    complete_run;
  end
endmodule // testbench
`default_nettype wire
